// ---- logic/pipeline_interlock_control.sv ----
`timescale 1ns/1ps
module pipeline_interlock_control
	import pipe_ilk_pkg::*;
#(
	parameter int NREGS = NUM_GPR
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 ex_valid,
	input  wire logic [REG_IDX_W-1:0] ex_rs,
	input  wire logic                 ex_uses_rs,
	input  wire logic [REG_IDX_W-1:0] ex_rt,
	input  wire logic                 ex_uses_rt,
	input  wire logic [REG_IDX_W-1:0] ex_rd,
	input  wire logic                 ex_writes_rd,
	input  wire logic                 ex_is_load,
	input  wire logic                 ex_is_barrier,
	input  wire logic                 ex_is_branch,
	input  wire logic                 ex_is_debug_return,
	input  wire logic                 ex_is_trap,
	input  wire logic                 ex_is_nop,
	input  wire md_op_type            ex_md_op,
	input  wire logic                 dc_miss,
	input  wire logic                 bus_rd_done,
	input  wire logic                 ld_wb_valid,
	input  wire logic [REG_IDX_W-1:0] ld_wb_reg,
	input  wire logic                 dbg_enter,
	output logic                      stall,
	output logic                      ex_advance,
	output logic                      delay_slot,
	output logic                      trap_in_slot,
	output logic                      slot_fault,
	output logic                      debug_mode,
	output logic                      irq_hold,
	output logic                      bus_pending,
	output logic                      pair_undef
);

	if (NREGS != (1 << REG_IDX_W)) begin : g_bad_nregs
		$error("pipeline_interlock_control: NREGS must match the register index width");
	end

	// Register zero is hard-wired, so it can never be a pending destination
	function automatic logic sb_hit(logic [NREGS-1:0] sb, logic [REG_IDX_W-1:0] idx,
			logic en);
		return en && idx != ZERO_REG && sb[idx];  // see RULE18
	endfunction

	logic [NREGS-1:0] sb_q, sb_d;
	logic             bus_pend_q, bus_pend_d;
	logic             raw_hit;
	logic             waw_hit;
	logic             bar_hit;
	logic             md_stall;

	// Scoreboard of load destinations still waiting for their data
	always_comb begin
		sb_d = sb_q;
		if (ld_wb_valid)
			sb_d[ld_wb_reg] = 1'b0;
		// A new load entering in the same cycle as a writeback keeps its bit set
		if (ex_advance && ex_is_load && ex_rd != ZERO_REG)
			sb_d[ex_rd] = 1'b1;  // see RULE17
		sb_d[ZERO_REG] = 1'b0;  // see RULE18
		bus_pend_d = bus_pend_q;
		if (bus_rd_done)
			bus_pend_d = 1'b0;
		if (dc_miss)
			bus_pend_d = 1'b1;  // see RULE3
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sb_q       <= NREGS'(SB_RESET);
			bus_pend_q <= 1'b0;
		end else begin
			sb_q       <= sb_d;
			bus_pend_q <= bus_pend_d;
		end
	end

	md_interlock u_md (
		.ref_clk      (ref_clk),
		.srst         (srst),
		.ex_valid     (ex_valid),
		.ex_advance   (ex_advance),
		.ex_md_op     (ex_md_op),
		.ex_rs        (ex_rs),
		.ex_uses_rs   (ex_uses_rs),
		.ex_rt        (ex_rt),
		.ex_uses_rt   (ex_uses_rt),
		.ex_rd        (ex_rd),
		.ex_writes_rd (ex_writes_rd),
		.md_stall     (md_stall),
		.pair_undef   (pair_undef)
	);

	// Stall terms; any one of them holds the execute stage, including barrier and multiply/divide stalls with no register match
	always_comb begin
		raw_hit = ex_valid && (sb_hit(sb_q, ex_rs, ex_uses_rs)
			|| sb_hit(sb_q, ex_rt, ex_uses_rt));                 // see RULE2 see RULE4
		waw_hit = ex_valid && sb_hit(sb_q, ex_rd, ex_writes_rd);  // see RULE6
		// Miss reported in the same cycle covers a barrier right behind the load
		bar_hit = ex_valid && ex_is_barrier && (bus_pend_q || dc_miss);  // see RULE7 see RULE8
		stall = raw_hit || waw_hit || bar_hit || md_stall;       // see RULE5
		ex_advance = ex_valid && !stall;                         // see RULE1
	end

	logic slot_q, slot_d;
	logic dret_slot_q, dret_slot_d;
	logic dbg_q, dbg_d;
	logic trap_slot_q, trap_slot_d;
	logic fault_q, fault_d;

	// Delay slot tracking and debug mode
	always_comb begin
		slot_d = slot_q;
		dret_slot_d = dret_slot_q;
		dbg_d = dbg_q;
		trap_slot_d = 1'b0;
		fault_d = 1'b0;
		if (ex_advance) begin
			slot_d = ex_is_branch || ex_is_debug_return;  // see RULE9
			dret_slot_d = ex_is_debug_return;
			// A trap in a slot must report the branch so the branch re-executes
			trap_slot_d = slot_q && ex_is_trap;  // see RULE10
			fault_d = (slot_q && (ex_is_branch || ex_is_debug_return))
				|| (dret_slot_q && !ex_is_nop);  // see RULE9 see RULE16
			if (dret_slot_q)
				dbg_d = 1'b0;  // see RULE16
		end
		// Entry wins over the exit that closes the slot
		if (dbg_enter)
			dbg_d = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slot_q      <= 1'b0;
			dret_slot_q <= 1'b0;
			dbg_q       <= 1'b0;
			trap_slot_q <= 1'b0;
			fault_q     <= 1'b0;
		end else begin
			slot_q      <= slot_d;
			dret_slot_q <= dret_slot_d;
			dbg_q       <= dbg_d;
			trap_slot_q <= trap_slot_d;
			fault_q     <= fault_d;
		end
	end

	assign delay_slot   = slot_q;
	assign trap_in_slot = trap_slot_q;
	assign slot_fault   = fault_q;
	assign debug_mode   = dbg_q;
	assign irq_hold     = dbg_q;
	assign bus_pending  = bus_pend_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	property p_hold;
		stall |-> !ex_advance;
	endproperty
	a_hold: assert property (p_hold) else $error("advance while stalled"); // see RULE1

	property p_raw;
		ex_valid && ex_uses_rs && ex_rs != ZERO_REG && sb_q[ex_rs] |-> stall;
	endproperty
	a_raw: assert property (p_raw) else $error("source on pending load not stalled"); // see RULE4

	property p_waw;
		ex_valid && ex_writes_rd && ex_rd != ZERO_REG && sb_q[ex_rd] |-> stall;
	endproperty
	a_waw: assert property (p_waw) else $error("write-after-write not stalled"); // see RULE6

	property p_load_tracked;
		ex_advance && ex_is_load && ex_rd != ZERO_REG |=> sb_q[$past(ex_rd)];
	endproperty
	a_load_tracked: assert property (p_load_tracked) else $error("load not tracked"); // see RULE17

	property p_zero;
		!sb_q[ZERO_REG];
	endproperty
	a_zero: assert property (p_zero) else $error("register zero marked pending"); // see RULE18

	property p_barrier;
		ex_valid && ex_is_barrier && bus_pend_q |-> stall;
	endproperty
	a_barrier: assert property (p_barrier) else $error("barrier passed pending bus read"); // see RULE7

	property p_free;
		ex_valid && !raw_hit && !waw_hit && !md_stall && !bus_pend_q && !dc_miss
			|-> ex_advance;
	endproperty
	a_free: assert property (p_free) else $error("independent instruction stalled"); // see RULE5 see RULE8

	property p_dbg_slot;
		dbg_q && dret_slot_q && ex_advance && !dbg_enter |=> !dbg_q;
	endproperty
	a_dbg_slot: assert property (p_dbg_slot) else $error("debug mode not left after slot"); // see RULE16

	property p_slot_trap;
		slot_q && ex_advance && ex_is_trap |=> trap_in_slot;
	endproperty
	a_slot_trap: assert property (p_slot_trap) else $error("trap in slot not flagged"); // see RULE10

	property p_raw_rt;
		ex_valid && ex_uses_rt && ex_rt != ZERO_REG && sb_q[ex_rt] |-> stall;
	endproperty
	a_raw_rt: assert property (p_raw_rt) else $error("rt source not stalled"); // see RULE2

	property p_idle;
		!ex_valid |-> !ex_advance;
	endproperty
	a_idle: assert property (p_idle) else $error("advance with no instruction"); // see RULE1

	property p_wb_clear;
		ld_wb_valid && ld_wb_reg != ZERO_REG && !(ex_advance && ex_is_load && ex_rd == ld_wb_reg)
			|=> !sb_q[$past(ld_wb_reg)];
	endproperty
	a_wb_clear: assert property (p_wb_clear) else $error("writeback left bit set"); // see RULE4

	property p_sb_hold;
		!ld_wb_valid |=> (sb_q & $past(sb_q)) == $past(sb_q);
	endproperty
	a_sb_hold: assert property (p_sb_hold) else $error("pending bit lost"); // see RULE3

	property p_miss_set;
		dc_miss |=> bus_pend_q;
	endproperty
	a_miss_set: assert property (p_miss_set) else $error("miss not recorded"); // see RULE3

	property p_bus_keep;
		bus_pend_q && !bus_rd_done |=> bus_pend_q;
	endproperty
	a_bus_keep: assert property (p_bus_keep) else $error("bus read dropped early"); // see RULE7

	property p_bus_done;
		bus_rd_done && !dc_miss |=> !bus_pend_q;
	endproperty
	a_bus_done: assert property (p_bus_done) else $error("bus read not retired"); // see RULE8

	property p_bar_miss;
		ex_valid && ex_is_barrier && dc_miss |-> stall;
	endproperty
	a_bar_miss: assert property (p_bar_miss) else $error("barrier passed fresh miss"); // see RULE7

	property p_bar_free;
		ex_valid && ex_is_barrier && !bus_pend_q && !dc_miss && !raw_hit && !waw_hit && !md_stall
			|-> ex_advance;
	endproperty
	a_bar_free: assert property (p_bar_free) else $error("barrier stalled after hit"); // see RULE8

	property p_slot_set;
		ex_advance && (ex_is_branch || ex_is_debug_return) |=> delay_slot;
	endproperty
	a_slot_set: assert property (p_slot_set) else $error("delay slot not marked"); // see RULE9

	property p_slot_clr;
		ex_advance && !ex_is_branch && !ex_is_debug_return |=> !delay_slot;
	endproperty
	a_slot_clr: assert property (p_slot_clr) else $error("stale delay slot"); // see RULE9

	property p_slot_branch;
		slot_q && ex_advance && ex_is_branch |=> slot_fault;
	endproperty
	a_slot_branch: assert property (p_slot_branch) else $error("branch in slot not reported"); // see RULE9

	property p_no_trap;
		!(slot_q && ex_advance && ex_is_trap) |=> !trap_in_slot;
	endproperty
	a_no_trap: assert property (p_no_trap) else $error("spurious trap in slot"); // see RULE10

	property p_md_hold;
		ex_valid && md_stall |-> stall;
	endproperty
	a_md_hold: assert property (p_md_hold) else $error("multiply interlock ignored"); // see RULE11

	property p_dret_nop;
		dret_slot_q && ex_advance && !ex_is_nop |=> slot_fault;
	endproperty
	a_dret_nop: assert property (p_dret_nop) else $error("busy debug return slot"); // see RULE16

	property p_dbg_enter;
		dbg_enter |=> debug_mode;
	endproperty
	a_dbg_enter: assert property (p_dbg_enter) else $error("debug entry lost"); // see RULE16

	property p_dbg_keep;
		dbg_q && !(dret_slot_q && ex_advance) |=> dbg_q;
	endproperty
	a_dbg_keep: assert property (p_dbg_keep) else $error("debug mode left early"); // see RULE16

	property p_irq_hold;
		irq_hold == debug_mode;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupts not held in debug"); // see RULE16

	c_raw_stall: cover property (raw_hit ##1 !raw_hit && ex_advance);
	c_barrier: cover property (bar_hit [*3] ##1 ex_advance);
	c_dret: cover property (ex_advance && ex_is_debug_return ##1 ex_advance && ex_is_nop);
	c_waw: cover property (waw_hit);

endmodule // pipeline_interlock_control

// ---- logic/pipe_ilk_pkg.sv ----
// Behaviour
// RULE1 - A detected hazard stalls the instruction; no advance until it clears.
// RULE2 - Reading the prior load's destination stalls until the cache returns data.
// RULE3 - Load misses and uncached loads also stall dependants until data arrives.
// RULE4 - Source matching a pending load destination holds in execute until writeback.
// RULE5 - Independent instructions proceed; only the first dependant stalls.
// RULE6 - Destination matching a pending load destination stalls until writeback.
// RULE7 - Barrier right after a load stalls until its bus cycle completes.
// RULE8 - Barrier after a cache-hit load passes without stall.
// RULE9 - Branch, jump, debug return own one delay slot; branches there are undefined.
// RULE10 - Traps in a delay slot are handled correctly.
// RULE11 - Register dependency between consecutive multiply/divide class instructions stalls.
// RULE12 - Next instruction stalls after a three-operand word multiply or accumulate.
// RULE13 - Word and doubleword multiply/divide in sequence stall, either order.
// RULE14 - Product pair undefined if read two instructions before a divide.
// RULE15 - Divide depending on preceding multiply holds in execute three cycles.
// RULE16 - Debug return slot must be a no-op; debug mode holds through it.
// RULE17 - Scoreboard of pending load destinations checked each cycle in execute.
// RULE18 - Register zero never counts as a dependency.
package pipe_ilk_pkg;

	localparam int             REG_IDX_W      = 5;
	localparam int             NUM_GPR        = 32;
	localparam logic [4:0]     ZERO_REG       = 5'h00;
	localparam int             MD_CNT_W       = 2;
	localparam logic [1:0]     MD_ILK_CYCLES  = 2'h1;
	localparam logic [1:0]     DIV_DEP_CYCLES = 2'h3;
	localparam logic [31:0]    SB_RESET       = 32'h0000_0000;

	typedef enum logic [3:0] {
		MD_NONE,
		MD_WMUL2,
		MD_WMUL3,
		MD_WMAC2,
		MD_WMAC3,
		MD_MOVE_TO,
		MD_MOVE_FROM,
		MD_WDIV,
		MD_DMUL2,
		MD_DMUL3,
		MD_DDIV
	} md_op_type;

endpackage

// ---- logic/md_interlock.sv ----
`timescale 1ns/1ps
module md_interlock
	import pipe_ilk_pkg::*;
#(
	parameter logic [1:0] ILK_CYCLES = MD_ILK_CYCLES,
	parameter logic [1:0] DEP_CYCLES = DIV_DEP_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 ex_valid,
	input  wire logic                 ex_advance,
	input  wire md_op_type            ex_md_op,
	input  wire logic [REG_IDX_W-1:0] ex_rs,
	input  wire logic                 ex_uses_rs,
	input  wire logic [REG_IDX_W-1:0] ex_rt,
	input  wire logic                 ex_uses_rt,
	input  wire logic [REG_IDX_W-1:0] ex_rd,
	input  wire logic                 ex_writes_rd,
	output logic                      md_stall,
	output logic                      pair_undef
);

	if (ILK_CYCLES == 2'h0 || DEP_CYCLES == 2'h0) begin : g_bad_cycles
		$error("md_interlock: stall lengths must be at least one cycle");
	end

	function automatic logic is_md(md_op_type op);
		return op != MD_NONE;
	endfunction

	function automatic logic is_mul(md_op_type op);
		return op inside {MD_WMUL2, MD_WMUL3, MD_WMAC2, MD_WMAC3, MD_DMUL2, MD_DMUL3};
	endfunction

	function automatic logic is_div(md_op_type op);
		return op inside {MD_WDIV, MD_DDIV};
	endfunction

	// Preceding/succeeding pairs that interlock without any register dependency
	function automatic logic table_ilk(md_op_type p, md_op_type s);
		logic r;
		r = 1'b0;
		case (p)
			MD_WMUL2, MD_WMAC2: r = is_md(s) && !(s inside {MD_WMUL2, MD_WMUL3, MD_WMAC2, MD_WMAC3});
			MD_WMUL3, MD_WMAC3, MD_WDIV, MD_DMUL2, MD_DMUL3, MD_DDIV: r = is_md(s);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	md_op_type            prev_op_q, prev_op_d;
	logic [REG_IDX_W-1:0] prev_rd_q, prev_rd_d;
	logic                 prev_wr_q, prev_wr_d;
	logic [1:0]           mf_hist_q, mf_hist_d;
	logic [MD_CNT_W-1:0]  cnt_q, cnt_d;
	logic                 armed_q, armed_d;
	logic                 undef_q, undef_d;
	logic                 dep;
	logic                 hazard;
	logic                 div_dep;
	logic                 start;

	always_comb begin
		dep = prev_wr_q && prev_rd_q != ZERO_REG
			&& ((ex_uses_rs && ex_rs == prev_rd_q) || (ex_uses_rt && ex_rt == prev_rd_q));
		div_dep = ex_valid && is_div(ex_md_op) && is_mul(prev_op_q) && dep;  // see RULE15
		hazard  = ex_valid && ((is_md(ex_md_op) && dep)                     // see RULE11
			|| prev_op_q inside {MD_WMUL3, MD_WMAC3}                         // see RULE12
			|| table_ilk(prev_op_q, ex_md_op));                              // see RULE13
		start = hazard && !armed_q;
		md_stall = start || cnt_q != '0;
		cnt_d = cnt_q;
		armed_d = armed_q;
		if (start) begin
			cnt_d = div_dep ? DEP_CYCLES - 2'h1 : ILK_CYCLES - 2'h1;
			armed_d = 1'b1;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 2'h1;
		end
		if (ex_advance)
			armed_d = 1'b0;
		prev_op_d = prev_op_q;
		prev_rd_d = prev_rd_q;
		prev_wr_d = prev_wr_q;
		mf_hist_d = mf_hist_q;
		undef_d = 1'b0;
		if (ex_advance) begin
			prev_op_d = ex_md_op;
			prev_rd_d = ex_rd;
			prev_wr_d = ex_writes_rd;
			mf_hist_d = {mf_hist_q[0], ex_md_op == MD_MOVE_FROM};
			// Pair read in either of the two instructions before a divide is not preserved; flag it for software
			undef_d = is_div(ex_md_op) && mf_hist_q != 2'b00;  // see RULE14
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prev_op_q <= MD_NONE;
			prev_rd_q <= ZERO_REG;
			prev_wr_q <= 1'b0;
			mf_hist_q <= 2'b00;
			cnt_q     <= '0;
			armed_q   <= 1'b0;
			undef_q   <= 1'b0;
		end else begin
			prev_op_q <= prev_op_d;
			prev_rd_q <= prev_rd_d;
			prev_wr_q <= prev_wr_d;
			mf_hist_q <= mf_hist_d;
			cnt_q     <= cnt_d;
			armed_q   <= armed_d;
			undef_q   <= undef_d;
		end
	end

	assign pair_undef = undef_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	property p_div_dep_hold;
		start && div_dep |-> md_stall [*3] ##1 !md_stall;
	endproperty
	a_div_dep_hold: assert property (p_div_dep_hold) else $error("dependent divide not held three cycles"); // see RULE15

	property p_mul3_next;
		ex_valid && prev_op_q inside {MD_WMUL3, MD_WMAC3} && !armed_q |-> md_stall;
	endproperty
	a_mul3_next: assert property (p_mul3_next) else $error("no stall after three-operand multiply"); // see RULE12

	property p_mix_width;
		ex_valid && !armed_q && prev_op_q == MD_WDIV && ex_md_op inside {MD_DMUL2, MD_DDIV}
			|-> md_stall;
	endproperty
	a_mix_width: assert property (p_mix_width) else $error("word/dword sequence not interlocked"); // see RULE13

	c_div_dep: cover property (start && div_dep);

endmodule // md_interlock

// ---- dv/dcache_model.sv ----
`timescale 1ns/1ps
module dcache_model
	import pipe_ilk_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 ld_go,
	input  wire logic [REG_IDX_W-1:0] ld_reg,
	input  wire logic                 miss_sel,
	input  wire logic [2:0]           lat_sel,
	output logic                      dc_miss,
	output logic                      bus_rd_done,
	output logic                      ld_wb_valid,
	output logic [REG_IDX_W-1:0]      ld_wb_reg
);
	logic [2:0]           cnt_q;
	logic                 miss_q;
	logic [REG_IDX_W-1:0] reg_q;

	// One access at a time: a second load before the first returns is not modelled
	always_ff @(posedge ref_clk) begin
		dc_miss     <= 1'b0;
		bus_rd_done <= 1'b0;
		ld_wb_valid <= 1'b0;
		// Idle register lines toggle so a stale number never looks valid
		ld_wb_reg   <= ~ld_wb_reg;
		if (srst) begin
			cnt_q     <= 3'h0;
			ld_wb_reg <= 5'h00;
		end else if (ld_go) begin
			dc_miss <= miss_sel;
			miss_q  <= miss_sel;
			reg_q   <= ld_reg;
			cnt_q   <= lat_sel - 3'h1;
			if (lat_sel == 3'h1) begin
				ld_wb_valid <= 1'b1;
				ld_wb_reg   <= ld_reg;
			end
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
			if (cnt_q == 3'h1) begin
				ld_wb_valid <= 1'b1;
				bus_rd_done <= miss_q;
				ld_wb_reg   <= reg_q;
			end
		end
	end
endmodule // dcache_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import pipe_ilk_pkg::*;
	typedef struct packed {
		logic [5:0] k;
		md_op_type  op;
		logic [4:0] rs;
		logic [4:0] rd;
	} instr_type;
	localparam logic [5:0] K_ALU = 6'h00, K_LD = 6'h20, K_BAR = 6'h10, K_BR = 6'h08;
	localparam logic [5:0] K_DR = 6'h04, K_TR = 6'h02, K_NOP = 6'h01;
	logic       ref_clk = 1'b0, srst = 1'b1, ex_valid = 1'b0, dbg_enter = 1'b0;
	logic       miss_sel = 1'b0, src_on_rt = 1'b0;
	logic [2:0] lat_sel = 3'h1;
	instr_type  cur = '0;
	logic       stall, ex_advance, delay_slot, trap_in_slot, slot_fault, debug_mode, irq_hold;
	logic       bus_pending, pair_undef, dc_miss, bus_rd_done, ld_wb_valid;
	logic [4:0] ld_wb_reg;
	logic [7:0] snap;
	int         bad_count = 0, n_compared = 0, seed = 32'h2a45;

	always #2 ref_clk = ~ref_clk;

	pipeline_interlock_control DUT (.ref_clk(ref_clk), .srst(srst), .ex_valid(ex_valid),
		.ex_rs(src_on_rt ? 5'h00 : cur.rs), .ex_uses_rs(1'b1),
		.ex_rt(src_on_rt ? cur.rs : 5'h00), .ex_uses_rt(1'b1), .ex_rd(cur.rd),
		.ex_writes_rd(cur.rd != 5'h00), .ex_is_load(cur.k[5]), .ex_is_barrier(cur.k[4]),
		.ex_is_branch(cur.k[3]), .ex_is_debug_return(cur.k[2]), .ex_is_trap(cur.k[1]),
		.ex_is_nop(cur.k[0]), .ex_md_op(cur.op), .dc_miss(dc_miss), .bus_rd_done(bus_rd_done),
		.ld_wb_valid(ld_wb_valid), .ld_wb_reg(ld_wb_reg), .dbg_enter(dbg_enter), .stall(stall),
		.ex_advance(ex_advance), .delay_slot(delay_slot), .trap_in_slot(trap_in_slot),
		.slot_fault(slot_fault), .debug_mode(debug_mode), .irq_hold(irq_hold),
		.bus_pending(bus_pending), .pair_undef(pair_undef));

	dcache_model partner (.ref_clk(ref_clk), .srst(srst), .ld_go(ex_advance && cur.k[5]),
		.ld_reg(cur.rd), .miss_sel(miss_sel), .lat_sel(lat_sel), .dc_miss(dc_miss),
		.bus_rd_done(bus_rd_done), .ld_wb_valid(ld_wb_valid), .ld_wb_reg(ld_wb_reg));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Holds the instruction until it leaves execute; exp < 0 skips the stall count
	task automatic run(input instr_type i, input int exp);
		int n;
		n = 0;
		cur <= i;
		ex_valid <= 1'b1;
		@(negedge ref_clk);
		snap = {delay_slot, trap_in_slot, slot_fault, debug_mode, irq_hold, bus_pending,
			pair_undef, dc_miss};
		while (ex_advance !== 1'b1) begin
			n++;
			if (n > 60) begin
				bad_count++;
				final_report();
			end
			@(negedge ref_clk);
		end
		chk(stall, 1'b0);
		@(posedge ref_clk);
		if (exp >= 0) begin
			chk(32'(n), 32'(exp));
		end
	endtask

	function automatic instr_type ins(input logic [5:0] k, input md_op_type op,
		input logic [4:0] rs, input logic [4:0] rd);
		return '{k, op, rs, rd};
	endfunction

	function automatic int exp_md(input md_op_type p, input md_op_type n);
		if (p == MD_MOVE_TO || p == MD_MOVE_FROM) return 0;
		if ((p == MD_WMUL2 || p == MD_WMAC2) && n inside {MD_WMUL2, MD_WMUL3, MD_WMAC2, MD_WMAC3})
			return 0;
		return 1;
	endfunction

	task automatic dbg_pulse();
		// Empty execute slot so the last instruction is not issued twice
		ex_valid <= 1'b0;
		dbg_enter <= 1'b1;
		@(posedge ref_clk);
		dbg_enter <= 1'b0;
	endtask

	initial begin
		logic [4:0] r, r2;
		logic       m;
		int         lat;
		md_op_type  p, n;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		for (int it = 0; it < 8; it++) begin
			r = 5'(1 + ($unsigned($random(seed)) % 31));
			r2 = (r == 5'h1f) ? 5'h01 : r + 5'h01;
			lat = 1 + ($unsigned($random(seed)) % 4);
			m = (lat > 1) && ($random(seed) & 1);
			miss_sel <= m;
			src_on_rt <= ($random(seed) & 1) != 0;
			lat_sel <= 3'(lat);
			run(ins(K_LD, MD_NONE, 5'h00, r), 0);
			run(ins(K_ALU, MD_NONE, r, r2), lat);
			run(ins(K_LD, MD_NONE, 5'h00, r), 0);
			run(ins(K_ALU, MD_NONE, r2, r2), 0);
			run(ins(K_ALU, MD_NONE, r, 5'h00), lat - 1);
			chk(snap[2], m);
			run(ins(K_LD, MD_NONE, 5'h00, r), 0);
			run(ins(K_ALU, MD_NONE, r2, r), lat);
			run(ins(K_LD, MD_NONE, 5'h00, 5'h00), 0);
			run(ins(K_ALU, MD_NONE, 5'h00, 5'h00), 0);
			repeat (4) run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
			run(ins(K_LD, MD_NONE, 5'h00, r), 0);
			run(ins(K_BAR, MD_NONE, 5'h00, 5'h00), m ? lat : 0);
			repeat (4) run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		end
		$display("test loads done");
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), -1);
		for (int a = 1; a <= 10; a++) begin
			for (int b = 1; b <= 10; b++) begin
				p = md_op_type'(a);
				n = md_op_type'(b);
				run(ins(K_ALU, p, 5'h0c, 5'h0a), -1);
				run(ins(K_ALU, n, 5'h0b, 5'h00), exp_md(p, n));
				run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), -1);
				chk(snap[1], p == MD_MOVE_FROM && n inside {MD_WDIV, MD_DDIV});
			end
		end
		run(ins(K_ALU, MD_WMUL3, 5'h0c, 5'h0a), -1);
		run(ins(K_ALU, MD_WDIV, 5'h0a, 5'h00), 3);
		$display("test multiply divide done");
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), -1);
		run(ins(K_BR, MD_NONE, 5'h00, 5'h00), 0);
		run(ins(K_TR, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[7], 1'b1);
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[6], 1'b1);
		chk(snap[7], 1'b0);
		run(ins(K_BR, MD_NONE, 5'h00, 5'h00), 0);
		run(ins(K_BR, MD_NONE, 5'h00, 5'h00), 0);
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[5], 1'b1);
		$display("test delay slot done");
		dbg_pulse();
		run(ins(K_DR, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[4], 1'b1);
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[4:3], 2'h3);
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[4:3], 2'h0);
		dbg_pulse();
		run(ins(K_DR, MD_NONE, 5'h00, 5'h00), 0);
		run(ins(K_ALU, MD_NONE, 5'h00, 5'h00), 0);
		run(ins(K_NOP, MD_NONE, 5'h00, 5'h00), 0);
		chk(snap[5], 1'b1);
		$display("test debug return done");
		final_report();
	end
endmodule // tb_top
